// *** hw/fcrp_pkg.sv ***
package fcrp_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_COND = 8'h08;
    localparam logic [7:0] OFF_FXER = 8'h0c;
    localparam logic [7:0] OFF_REGF = 8'h80;
    localparam int CTRL_SUP = 0;
    localparam int CTRL_END = 1;
    localparam int CTRL_SLP = 2;
    localparam int FXER_CA = 0;
    localparam int FXER_OV = 1;
    localparam logic [31:0] PROG_VEC = 32'h0000_0700;
    localparam logic [31:0] ALIGN_VEC = 32'h0000_0000;
    localparam logic [1:0] CAUSE_PROG = 2'h0;
    localparam logic [1:0] CAUSE_ALIGN = 2'h1;
    localparam logic [1:0] CAUSE_PRIV = 2'h2;
    localparam logic [1:0] CAUSE_UNREC = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_DEC = 3'h2,
        ST_EXE = 3'h4
    } fcrp_state_t;

    typedef struct packed {
        logic creg, falign, besteer, wrback, load, store, priv;
        logic need_a, need_b, upd, ca, ov, fp;
        logic trap_be, trap_le;
        logic [4:0] size;
    } fcrp_dec_t;

    typedef struct packed {
        fcrp_dec_t dec;
        logic [31:0] result;
        logic carry, ovf;
        logic [3:0] cbits;
        logic [2:0] field;
        logic rvalid, done, exc, blk, nblk;
        logic ack, busy, ldwait, sleepnr;
    } fcrp_resp_t;

    typedef struct packed {
        logic offer;
        logic [4:0] first, second, target;
        logic [31:0] ea;
    } fcrp_core_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [4:0] size;
        logic load, store, be_steer;
    } fcrp_mem_t;

    typedef struct packed {
        logic taken;
        logic [1:0] cause;
        logic [31:0] vector;
    } fcrp_exc_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } fcrp_axi_req_t;

    typedef struct packed {
        logic awready, wready, bvalid;
        logic [1:0] bresp;
        logic arready, rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fcrp_axi_rsp_t;
endpackage

// *** hw/fcrp_port.sv ***
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module fcrp_port (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // Register bus
    input wire fcrp_pkg::fcrp_axi_req_t AXI_REQ,
    output fcrp_pkg::fcrp_axi_rsp_t AXI_RSP,
    // Coprocessor responses
    input wire fcrp_pkg::fcrp_resp_t FC_RESP,
    // Core side
    input wire fcrp_pkg::fcrp_core_t CORE_REQ,
    output logic BUSY,
    output logic STALL,
    output logic [31:0] OPERAND_A,
    output logic [31:0] OPERAND_B,
    output fcrp_pkg::fcrp_mem_t MEM_REQ,
    output fcrp_pkg::fcrp_exc_t EXC,
    output logic SLEEP_OK,
    // Load data towards the coprocessor
    input wire logic LD_IN_VALID,
    input wire logic [31:0] LD_IN_DATA,
    output logic LD_IN_READY,
    output logic LD_OUT_VALID,
    output logic [31:0] LD_OUT_DATA
);
    typedef struct packed {
        fcrp_pkg::fcrp_state_t st;
        fcrp_pkg::fcrp_dec_t dec;
        logic [4:0] tgt, base;
        logic [31:0] ea, opa, opb, cond, ldd;
        logic ca, ov, sup, endn, slpreq, slp, got, blk, ldv;
        fcrp_pkg::fcrp_exc_t exc;
        logic [31:0][31:0] regf;
        logic aw_h, w_h, bv, rv;
        logic [1:0] bresp, rresp;
        logic [7:0] awa;
        logic [31:0] wd, rd;
        logic [3:0] ws;
    } fcrp_regs_t;

    fcrp_regs_t r, n;
    fcrp_pkg::fcrp_resp_t rsp;
    logic take;
    logic [31:0] waddr_val;
    logic [32:0] wmux;

    assign rsp = FC_RESP;
    // Decode results count only with acknowledge and without busy.
    assign take = r.st == fcrp_pkg::ST_DEC && rsp.ack && !rsp.busy;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] ws);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (ws[i]) begin
                res[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [32:0] rd_mux(input fcrp_regs_t s,
                                           input logic [7:0] a);
        logic [32:0] res;
        res = {1'b1, 32'h0};
        if (a >= fcrp_pkg::OFF_REGF) begin
            res = {1'b1, s.regf[a[6:2]]};
        end else if (a == fcrp_pkg::OFF_CTRL) begin
            res[fcrp_pkg::CTRL_SUP] = s.sup;
            res[fcrp_pkg::CTRL_END] = s.endn;
            res[fcrp_pkg::CTRL_SLP] = s.slpreq;
        end else if (a == fcrp_pkg::OFF_STAT) begin
            res[31:0] = {22'h0, s.exc.cause, s.slp, s.got, s.blk,
                         s.dec.fp, 1'b0, s.st};
        end else if (a == fcrp_pkg::OFF_COND) begin
            res[31:0] = s.cond;
        end else if (a == fcrp_pkg::OFF_FXER) begin
            res[fcrp_pkg::FXER_CA] = s.ca;
            res[fcrp_pkg::FXER_OV] = s.ov;
        end else begin
            res = 33'h0;
        end
        return res;
    endfunction

    // The mapped flag is dropped here; only the word feeds the merge.
    assign wmux = rd_mux(r, r.awa);
    assign waddr_val = wmux[31:0];

    always_comb begin
        logic [32:0] rm;
        logic [31:0] wv;
        rm = 33'h0;
        wv = 32'h0;
        n = r;
        n.exc.taken = 1'b0;

        // Register bus: address and data may arrive in either order.
        if (AXI_REQ.awvalid && AXI_RSP.awready) begin
            n.aw_h = 1'b1;
            n.awa = AXI_REQ.awaddr;
        end
        if (AXI_REQ.wvalid && AXI_RSP.wready) begin
            n.w_h = 1'b1;
            n.wd = AXI_REQ.wdata;
            n.ws = AXI_REQ.wstrb;
        end
        if (r.aw_h && r.w_h) begin
            wv = merge(waddr_val, r.wd, r.ws);
            n.aw_h = 1'b0;
            n.w_h = 1'b0;
            n.bv = 1'b1;
            n.bresp = fcrp_pkg::RESP_SLVERR;
            if (rd_mux(r, r.awa) != 33'h0 || r.awa == fcrp_pkg::OFF_STAT
                    || r.awa == fcrp_pkg::OFF_FXER
                    || r.awa == fcrp_pkg::OFF_CTRL
                    || r.awa == fcrp_pkg::OFF_COND
                    || r.awa >= fcrp_pkg::OFF_REGF) begin
                n.bresp = fcrp_pkg::RESP_OKAY;
            end
            if (r.awa >= fcrp_pkg::OFF_REGF) begin
                n.regf[r.awa[6:2]] = wv;
            end else if (r.awa == fcrp_pkg::OFF_CTRL) begin
                n.sup = wv[fcrp_pkg::CTRL_SUP];
                n.endn = wv[fcrp_pkg::CTRL_END];
                n.slpreq = wv[fcrp_pkg::CTRL_SLP];
            end else if (r.awa == fcrp_pkg::OFF_COND) begin
                n.cond = wv;
            end else if (r.awa == fcrp_pkg::OFF_FXER) begin
                n.ca = wv[fcrp_pkg::FXER_CA];
                n.ov = wv[fcrp_pkg::FXER_OV];
            end
        end
        if (r.bv && AXI_REQ.bready) begin
            n.bv = 1'b0;
        end
        if (AXI_REQ.arvalid && AXI_RSP.arready) begin
            rm = rd_mux(r, AXI_REQ.araddr);
            n.rv = 1'b1;
            n.rd = rm[31:0];
            n.rresp = rm[32] ? fcrp_pkg::RESP_OKAY : fcrp_pkg::RESP_SLVERR;
        end else if (r.rv && AXI_REQ.rready) begin
            n.rv = 1'b0;
        end

        // Load words pass only while the coprocessor can take them.
        n.ldv = LD_IN_VALID && !rsp.ldwait;
        if (LD_IN_VALID && !rsp.ldwait) begin
            n.ldd = LD_IN_DATA;
        end

        // Sleep is granted only to an idle port with no work pending.
        n.slp = r.slpreq && !rsp.sleepnr && r.st == fcrp_pkg::ST_IDLE;

        // The core logic wins over a bus write in the same cycle.
        unique case (r.st)
            fcrp_pkg::ST_IDLE: begin
                if (CORE_REQ.offer) begin
                    n.st = fcrp_pkg::ST_DEC;
                    n.tgt = CORE_REQ.target;
                    n.base = CORE_REQ.first;
                    n.ea = CORE_REQ.ea;
                    n.opa = r.regf[CORE_REQ.first];
                    n.opb = r.regf[CORE_REQ.second];
                    n.dec = '0;
                    n.got = 1'b0;
                    n.blk = 1'b0;
                end
            end
            fcrp_pkg::ST_DEC: begin
                if (take) begin
                    n.dec = rsp.dec;
                    n.st = fcrp_pkg::ST_EXE;
                    n.opa = rsp.dec.need_a ? r.opa : 32'h0;
                    n.opb = rsp.dec.need_b ? r.opb : 32'h0;
                    if (rsp.dec.priv && !r.sup) begin
                        n.st = fcrp_pkg::ST_IDLE;
                        n.exc = '{1'b1, fcrp_pkg::CAUSE_PRIV,
                                  fcrp_pkg::PROG_VEC};
                    end else if ((rsp.dec.load || rsp.dec.store)
                            && ((rsp.dec.trap_be && !r.endn)
                            || (rsp.dec.trap_le && r.endn))) begin
                        n.st = fcrp_pkg::ST_IDLE;
                        n.exc = '{1'b1, fcrp_pkg::CAUSE_ALIGN,
                                  fcrp_pkg::ALIGN_VEC};
                    end else if (rsp.dec.upd
                            && (rsp.dec.load || rsp.dec.store)) begin
                        n.regf[r.base] = r.ea;
                    end
                end else if (!rsp.busy) begin
                    // Without acknowledge the opcode is not ours.
                    n.st = fcrp_pkg::ST_IDLE;
                    n.exc = '{1'b1, fcrp_pkg::CAUSE_UNREC,
                              fcrp_pkg::PROG_VEC};
                end
            end
            fcrp_pkg::ST_EXE: begin
                if (rsp.blk) begin
                    n.blk = 1'b1;
                end
                if (rsp.exc) begin
                    n.st = fcrp_pkg::ST_IDLE;
                    n.exc = '{1'b1, fcrp_pkg::CAUSE_PROG,
                              fcrp_pkg::PROG_VEC};
                end else begin
                    if (rsp.rvalid) begin
                        n.got = 1'b1;
                        if (r.dec.wrback) begin
                            n.regf[r.tgt] = rsp.result;
                        end
                        if (r.dec.creg) begin
                            n.cond[{~rsp.field, 2'b00} +: 4] = rsp.cbits;
                        end
                        if (r.dec.ca) begin
                            n.ca = rsp.carry;
                        end
                        if (r.dec.ov) begin
                            n.ov = rsp.ovf;
                        end
                    end
                    if (rsp.done) begin
                        n.st = fcrp_pkg::ST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            r <= '0;
            r.st <= fcrp_pkg::ST_IDLE;
        end else begin
            r <= n;
        end
    end

    assign AXI_RSP.awready = !r.aw_h && !r.bv;
    assign AXI_RSP.wready = !r.w_h && !r.bv;
    assign AXI_RSP.bvalid = r.bv;
    assign AXI_RSP.bresp = r.bresp;
    assign AXI_RSP.arready = !r.rv;
    assign AXI_RSP.rvalid = r.rv;
    assign AXI_RSP.rdata = r.rd;
    assign AXI_RSP.rresp = r.rresp;

    assign BUSY = r.st != fcrp_pkg::ST_IDLE;
    // A non-blocking operation stalls the pipeline only while in decode.
    assign STALL = r.st == fcrp_pkg::ST_DEC
        || (r.st == fcrp_pkg::ST_EXE && (r.blk || rsp.blk));
    assign OPERAND_A = r.opa;
    assign OPERAND_B = r.opb;
    assign MEM_REQ.addr = r.dec.falign ? {r.ea[31:2], 2'b00} : r.ea;
    assign MEM_REQ.size = r.dec.size;
    assign MEM_REQ.load = r.st == fcrp_pkg::ST_EXE && r.dec.load;
    assign MEM_REQ.store = r.st == fcrp_pkg::ST_EXE && r.dec.store;
    assign MEM_REQ.be_steer = (r.dec.besteer && r.dec.store) || !r.endn;
    assign EXC = r.exc;
    assign SLEEP_OK = r.slp;
    assign LD_IN_READY = !rsp.ldwait;
    assign LD_OUT_VALID = r.ldv;
    assign LD_OUT_DATA = r.ldd;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    sequence dec_take_s;
        r.st == fcrp_pkg::ST_DEC && rsp.ack && !rsp.busy;
    endsequence
    sequence exe_result_s;
        r.st == fcrp_pkg::ST_EXE && !rsp.exc && rsp.rvalid;
    endsequence

    result_writeback_a: assert property (
        exe_result_s ##0 r.dec.wrback |=> r.regf[$past(r.tgt)]
            == $past(rsp.result))
        else $error("result not written back");
    prog_vector_a: assert property (
        r.st == fcrp_pkg::ST_EXE && rsp.exc |=> EXC.taken
            && EXC.vector == fcrp_pkg::PROG_VEC
            && r.st == fcrp_pkg::ST_IDLE)
        else $error("program exception missing");
    endian_trap_a: assert property (
        dec_take_s ##0 (rsp.dec.load || rsp.dec.store) && r.sup
            && rsp.dec.trap_be && !r.endn
            |=> EXC.taken && EXC.cause == fcrp_pkg::CAUSE_ALIGN)
        else $error("alignment trap missing");
    decode_wait_a: assert property (
        r.st == fcrp_pkg::ST_DEC && rsp.busy |=> r.st == fcrp_pkg::ST_DEC
            && !EXC.taken)
        else $error("decode ended while busy");
    load_hold_a: assert property (
        rsp.ldwait |=> !r.ldv ##0 r.ldd == $past(r.ldd))
        else $error("load data passed during wait");
    cond_field_a: assert property (
        exe_result_s ##0 r.dec.creg |=> r.cond[{~$past(rsp.field), 2'b00}
            +: 4] == $past(rsp.cbits))
        else $error("condition field not written");
    word_align_a: assert property (
        r.dec.falign |-> MEM_REQ.addr[1:0] == 2'h0
            && MEM_REQ.addr[31:2] == r.ea[31:2])
        else $error("address not word aligned");
    priv_fault_a: assert property (
        dec_take_s ##0 rsp.dec.priv && !r.sup |=> EXC.taken
            && EXC.cause == fcrp_pkg::CAUSE_PRIV && !BUSY)
        else $error("privilege violation missed");
    unrec_instr_a: assert property (
        r.st == fcrp_pkg::ST_DEC && !rsp.ack && !rsp.busy |=> !BUSY
            && EXC.cause == fcrp_pkg::CAUSE_UNREC && r.dec == '0)
        else $error("unrecognized instruction accepted");
    operand_gate_a: assert property (
        dec_take_s ##0 !rsp.dec.need_a |=> OPERAND_A == 32'h0)
        else $error("first operand fetched unflagged");
    carry_return_a: assert property (
        exe_result_s ##0 r.dec.ca |=> r.ca == $past(rsp.carry))
        else $error("carry not returned");
    stall_class_a: assert property (
        r.st == fcrp_pkg::ST_EXE && rsp.blk |-> STALL ##1
            (r.st == fcrp_pkg::ST_EXE) [*1] |-> STALL)
        else $error("blocking operation did not stall");
    sleep_block_a: assert property (
        rsp.sleepnr |=> !SLEEP_OK)
        else $error("sleep granted while blocked");
endmodule

// *** dv/fcrp_copro_model.sv ***
`timescale 1ns/1ps
module fcrp_copro_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Behaviour chosen by the bench
    input wire fcrp_pkg::fcrp_resp_t tmpl,
    input wire logic [3:0] dec_wait,
    input wire logic [3:0] exe_wait,
    // Port side
    input wire logic busy,
    output fcrp_pkg::fcrp_resp_t resp
);
    typedef struct packed {
        logic [4:0] cnt;
    } fcrp_mst_t;
    fcrp_mst_t st_r;
    fcrp_mst_t st_nxt;
    logic [4:0] done_at;

    assign done_at = {1'b0, dec_wait} + {1'b0, exe_wait} + 5'h01;

    always_comb begin
        st_nxt = st_r;
        st_nxt.cnt = busy ? st_r.cnt + 5'h01 : 5'h00;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outside their own cycle the qualified values other than field carry inverted noise, so
    // a port that samples them early or late picks up wrong data.
    always_comb begin
        resp = tmpl;
        resp.dec = ~tmpl.dec;
        resp.ack = 1'b0;
        resp.busy = 1'b0;
        resp.result = ~tmpl.result;
        resp.carry = ~tmpl.carry;
        resp.ovf = ~tmpl.ovf;
        resp.cbits = ~tmpl.cbits;
        resp.rvalid = 1'b0;
        resp.done = 1'b0;
        resp.exc = 1'b0;
        if (tmpl == '0) begin
            resp = '0;
        end else if (busy && st_r.cnt < {1'b0, dec_wait}) begin
            resp.busy = 1'b1;
        end else if (busy && st_r.cnt == {1'b0, dec_wait}) begin
            resp.ack = tmpl.ack;
            resp.dec = tmpl.dec;
        end else if (busy && st_r.cnt == done_at) begin
            resp.rvalid = tmpl.rvalid;
            resp.result = tmpl.result;
            resp.carry = tmpl.carry;
            resp.ovf = tmpl.ovf;
            resp.cbits = tmpl.cbits;
            resp.done = tmpl.done;
            resp.exc = tmpl.exc;
        end
    end
endmodule

// *** dv/fcrp_port_tb.sv ***
`timescale 1ns/1ps
module fcrp_port_tb;
    logic clk_sys, rstn, ld_valid, BUSY, STALL, SLEEP_OK, LD_IN_READY;
    logic LD_OUT_VALID;
    logic [31:0] ld_data, OPERAND_A, OPERAND_B, LD_OUT_DATA, op_a, op_b, d;
    logic [3:0] dwait, ewait;
    logic [1:0] r;
    fcrp_pkg::fcrp_axi_req_t req;
    fcrp_pkg::fcrp_axi_rsp_t rsp;
    fcrp_pkg::fcrp_resp_t tmpl, fc, t;
    fcrp_pkg::fcrp_core_t core;
    fcrp_pkg::fcrp_mem_t MEM_REQ, mem_c;
    fcrp_pkg::fcrp_exc_t EXC, exc_c;
    int fail_count = 0, compares = 0, busy_n, stall_n, exc_n;

    fcrp_port fcrp_port_i (.CLK_SYS(clk_sys), .RSTN(rstn), .AXI_REQ(req),
        .AXI_RSP(rsp), .FC_RESP(fc), .CORE_REQ(core), .BUSY(BUSY),
        .STALL(STALL), .OPERAND_A(OPERAND_A), .OPERAND_B(OPERAND_B),
        .MEM_REQ(MEM_REQ), .EXC(EXC), .SLEEP_OK(SLEEP_OK),
        .LD_IN_VALID(ld_valid), .LD_IN_DATA(ld_data),
        .LD_IN_READY(LD_IN_READY), .LD_OUT_VALID(LD_OUT_VALID),
        .LD_OUT_DATA(LD_OUT_DATA));
    fcrp_copro_model fcrp_copro_model_i (.clk_sys(clk_sys), .rstn(rstn),
        .tmpl(tmpl), .dec_wait(dwait), .exe_wait(ewait), .busy(BUSY),
        .resp(fc));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (BUSY === 1'b1) begin
            busy_n++;
            op_a <= OPERAND_A;
            op_b <= OPERAND_B;
            if (STALL === 1'b1) stall_n++;
        end
        if (MEM_REQ.load === 1'b1 || MEM_REQ.store === 1'b1) mem_c <= MEM_REQ;
        if (EXC.taken === 1'b1) begin
            exc_n++;
            exc_c <= EXC;
        end
    end

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        logic b;
        n = 0;
        b = 1'b0;
        @(posedge clk_sys);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= v;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        while (!b && n < 50) begin
            @(posedge clk_sys);
            n++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) begin
                b = 1'b1;
                r = rsp.bresp;
            end
        end
        req.bready <= 1'b0;
        if (!b) fail_count++;
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        logic b;
        n = 0;
        b = 1'b0;
        @(posedge clk_sys);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        while (!b && n < 50) begin
            @(posedge clk_sys);
            n++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) begin
                b = 1'b1;
                d = rsp.rdata;
                r = rsp.rresp;
            end
        end
        req.rready <= 1'b0;
        if (!b) fail_count++;
    endtask

    task automatic run(input logic [3:0] dw, input logic [3:0] ew,
                       input logic [4:0] sa, input logic [4:0] sb,
                       input logic [31:0] ea);
        int n;
        n = 0;
        @(posedge clk_sys);
        busy_n = 0;
        stall_n = 0;
        exc_n = 0;
        tmpl <= t;
        dwait <= dw;
        ewait <= ew;
        core <= '{offer: 1'b1, first: sa, second: sb, target: 5'h05, ea: ea};
        @(posedge clk_sys);
        core.offer <= 1'b0;
        #1;
        while (BUSY === 1'b1 && n < 40) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 40) fail_count++;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic exc_is(input logic [1:0] c, input logic [31:0] v);
        check("exc_count", 32'(exc_n), 32'h1);
        check("exc_cause", 32'(exc_c.cause), 32'(c));
        check("exc_vector", exc_c.vector, v);
    endtask

    initial begin
        #2000000;
        fail_count++;
        end_of_test();
    end

    initial begin
        rstn = 1'b0;
        req = '0;
        tmpl = '0;
        t = '0;
        core = '0;
        dwait = 4'h0;
        ewait = 4'h0;
        ld_valid = 1'b0;
        ld_data = 32'h0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(fcrp_pkg::OFF_STAT);
        check("status_reset", d, 32'h1);
        rd(8'h40);
        check("unmapped_resp", 32'(r), 32'(fcrp_pkg::RESP_SLVERR));
        check("unmapped_data", d, 32'h0);
        wr(8'h40, 32'hffff_ffff);
        check("unmapped_bresp", 32'(r), 32'(fcrp_pkg::RESP_SLVERR));
        wr(fcrp_pkg::OFF_CTRL, 32'h1);
        check("ctrl_bresp", 32'(r), 32'(fcrp_pkg::RESP_OKAY));
        wr(8'h84, 32'h1111_1111);
        wr(8'h88, 32'h2222_2222);
        t.ack = 1'b1;
        t.dec.need_a = 1'b1;
        t.dec.need_b = 1'b1;
        t.dec.wrback = 1'b1;
        t.dec.creg = 1'b1;
        t.dec.ca = 1'b1;
        t.dec.ov = 1'b1;
        t.dec.fp = 1'b1;
        t.result = 32'hcafe_0001;
        t.carry = 1'b1;
        t.ovf = 1'b1;
        t.cbits = 4'ha;
        t.field = 3'h3;
        t.rvalid = 1'b1;
        t.done = 1'b1;
        t.blk = 1'b1;
        run(4'h2, 4'h1, 5'h01, 5'h02, 32'h0);
        check("busy_cycles", 32'(busy_n), 32'h5);
        check("stall_blocking", 32'(stall_n), 32'h5);
        check("operand_a", op_a, 32'h1111_1111);
        check("operand_b", op_b, 32'h2222_2222);
        rd(8'h94);
        check("regf_writeback", d, 32'hcafe_0001);
        rd(fcrp_pkg::OFF_COND);
        check("cond_field", d, 32'h000a_0000);
        rd(fcrp_pkg::OFF_FXER);
        check("carry_ovf", d, 32'h3);
        rd(fcrp_pkg::OFF_STAT);
        check("status_flags", d, 32'h71);
        t.dec = '0;
        t.result = 32'h1234_5678;
        t.carry = 1'b0;
        t.ovf = 1'b0;
        t.blk = 1'b0;
        t.nblk = 1'b1;
        run(4'h0, 4'h2, 5'h01, 5'h02, 32'h0);
        check("stall_nonblocking", 32'(stall_n), 32'h1);
        check("operand_a_off", op_a, 32'h0);
        check("operand_b_off", op_b, 32'h0);
        rd(8'h94);
        check("regf_kept", d, 32'hcafe_0001);
        rd(fcrp_pkg::OFF_FXER);
        check("carry_ovf_kept", d, 32'h3);
        t.nblk = 1'b0;
        t.dec.load = 1'b1;
        t.dec.upd = 1'b1;
        t.dec.falign = 1'b1;
        t.dec.size = 5'h04;
        run(4'h0, 4'h0, 5'h01, 5'h00, 32'h0000_1003);
        check("aligned_addr", mem_c.addr, 32'h0000_1000);
        check("size", 32'(mem_c.size), 32'h4);
        rd(8'h84);
        check("base_update", d, 32'h0000_1003);
        wr(fcrp_pkg::OFF_CTRL, 32'h3);
        t.dec = '0;
        t.dec.store = 1'b1;
        t.dec.size = 5'h01;
        t.dec.besteer = 1'b1;
        run(4'h0, 4'h0, 5'h00, 5'h00, 32'h0000_2000);
        check("steer_forced", 32'(mem_c.be_steer), 32'h1);
        t.dec.besteer = 1'b0;
        run(4'h0, 4'h0, 5'h00, 5'h00, 32'h0000_2000);
        check("steer_attr", 32'(mem_c.be_steer), 32'h0);
        t.dec.trap_le = 1'b1;
        run(4'h0, 4'h0, 5'h00, 5'h00, 32'h0);
        exc_is(fcrp_pkg::CAUSE_ALIGN, fcrp_pkg::ALIGN_VEC);
        t.dec.trap_le = 1'b0;
        t.dec.trap_be = 1'b1;
        run(4'h0, 4'h0, 5'h00, 5'h00, 32'h0);
        check("no_trap", 32'(exc_n), 32'h0);
        wr(fcrp_pkg::OFF_CTRL, 32'h1);
        run(4'h0, 4'h0, 5'h00, 5'h00, 32'h0);
        exc_is(fcrp_pkg::CAUSE_ALIGN, fcrp_pkg::ALIGN_VEC);
        t.dec = '0;
        t.dec.priv = 1'b1;
        run(4'h0, 4'h0, 5'h00, 5'h00, 32'h0);
        check("priv_super", 32'(exc_n), 32'h0);
        wr(fcrp_pkg::OFF_CTRL, 32'h0);
        run(4'h0, 4'h0, 5'h00, 5'h00, 32'h0);
        exc_is(fcrp_pkg::CAUSE_PRIV, fcrp_pkg::PROG_VEC);
        t.dec = '0;
        t.done = 1'b0;
        t.rvalid = 1'b0;
        t.exc = 1'b1;
        run(4'h0, 4'h1, 5'h00, 5'h00, 32'h0);
        exc_is(fcrp_pkg::CAUSE_PROG, fcrp_pkg::PROG_VEC);
        t = '0;
        run(4'h0, 4'h0, 5'h00, 5'h00, 32'h0);
        exc_is(fcrp_pkg::CAUSE_UNREC, fcrp_pkg::PROG_VEC);
        t.ldwait = 1'b1;
        @(posedge clk_sys);
        tmpl <= t;
        ld_valid <= 1'b1;
        ld_data <= 32'ha5a5_0001;
        repeat (2) @(posedge clk_sys);
        #1;
        check("ld_ready_wait", 32'(LD_IN_READY), 32'h0);
        check("ld_out_wait", 32'(LD_OUT_VALID), 32'h0);
        @(posedge clk_sys);
        tmpl.ldwait <= 1'b0;
        @(posedge clk_sys);
        ld_valid <= 1'b0;
        #1;
        check("ld_out_valid", 32'(LD_OUT_VALID), 32'h1);
        check("ld_out_data", LD_OUT_DATA, 32'ha5a5_0001);
        t.ldwait = 1'b0;
        t.sleepnr = 1'b1;
        @(posedge clk_sys);
        tmpl <= t;
        wr(fcrp_pkg::OFF_CTRL, 32'h5);
        repeat (3) @(posedge clk_sys);
        #1;
        check("sleep_blocked", 32'(SLEEP_OK), 32'h0);
        @(posedge clk_sys);
        tmpl.sleepnr <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        check("sleep_ok", 32'(SLEEP_OK), 32'h1);
        end_of_test();
    end
endmodule
